/* File: src/port_crossbar_and_match.sv */
// How it works
// - routing bit 7 routes timer1 input
// - routing bit 6 routes timer0 input
// - routing bit 5 routes pca counter input
// - field 4:2 routes pca modules cumulatively
// - routing bit 1 drives system clock out
// - master bit 7 disables all weak pullups
// - master bit 6 enables the crossbar
// - master bit 0 routes lin pair
// - masked pins differing from expected raise mismatch
// - mismatch ignores crossbar routing settings
// - mismatch feeds interrupt and wake-up
// - compare-select bit zero excludes that pin
// - expected-value bit gives compared level
// - crossbar off keeps output drivers off
module port_crossbar_and_match (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [port_xbar_pkg::PIN_W-1:0] pin_in,
  input wire logic [port_xbar_pkg::PIN_W-1:0] pin_analog,
  input wire logic [port_xbar_pkg::PIN_W-1:0] drv_req,
  output logic [port_xbar_pkg::PIN_W-1:0] drv_en,
  output logic [port_xbar_pkg::PIN_W-1:0] weak_pullup_en,
  output port_xbar_pkg::route_s route,
  output logic crossbar_on,
  output logic [port_xbar_pkg::NUM_PORTS-1:0] port_mismatch,
  output logic mismatch_irq,
  output logic mismatch_wake
);

  localparam int NP = port_xbar_pkg::NUM_PORTS;
  localparam int PW = port_xbar_pkg::PORT_W;

  logic [7:0] master_r;
  logic [7:0] master_nxt;
  logic [7:0] route_r;
  logic [7:0] route_nxt;
  logic [NP-1:0][PW-1:0] expect_r;
  logic [NP-1:0][PW-1:0] expect_nxt;
  logic [NP-1:0][PW-1:0] select_r;
  logic [NP-1:0][PW-1:0] select_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [port_xbar_pkg::PIN_W-1:0] pin_meta_r;
  logic [port_xbar_pkg::PIN_W-1:0] pin_sync_r;
  logic [NP-1:0] mismatch_r;
  logic [NP-1:0] mismatch_nxt;
  logic [2:0] pca_cnt;
  logic pullup_global_disable;
  logic [port_xbar_pkg::PCA_MODULES-1:0] pca_pins;
  logic [2:0] wr_pca_cnt;

  // register writes; reserved bits are stored as written
  always_comb begin
    master_nxt = master_r;
    route_nxt = route_r;
    expect_nxt = expect_r;
    select_nxt = select_r;
    if (sfr_wr) begin
      if (sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER) begin
        master_nxt = sfr_wdata;
      end
      if (sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE) begin
        route_nxt = sfr_wdata;
      end
      for (int p = 0; p < NP; p++) begin
        if (sfr_addr == port_xbar_pkg::ADDR_EXPECT[p]) begin
          expect_nxt[p] = sfr_wdata;
        end
        if (sfr_addr == port_xbar_pkg::ADDR_SELECT[p]) begin
          select_nxt[p] = sfr_wdata;
        end
      end
    end
  end

  // read mux, data held between reads
  always_comb begin
    rdata_nxt = rdata_r;
    if (sfr_rd) begin
      rdata_nxt = port_xbar_pkg::RDATA_UNMAPPED;
      if (sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER) begin
        rdata_nxt = master_r;
      end
      if (sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE) begin
        rdata_nxt = route_r;
      end
      for (int p = 0; p < NP; p++) begin
        if (sfr_addr == port_xbar_pkg::ADDR_EXPECT[p]) begin
          rdata_nxt = expect_r[p];
        end
        if (sfr_addr == port_xbar_pkg::ADDR_SELECT[p]) begin
          rdata_nxt = select_r[p];
        end
      end
    end
  end

  // register state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      master_r <= port_xbar_pkg::RST_XBAR_MASTER;
      route_r <= port_xbar_pkg::RST_XBAR_ROUTE;
      expect_r <= {NP{port_xbar_pkg::RST_EXPECT}};
      select_r <= {NP{port_xbar_pkg::RST_SELECT}};
      rdata_r <= port_xbar_pkg::RDATA_UNMAPPED;
    end else begin
      master_r <= master_nxt;
      route_r <= route_nxt;
      expect_r <= expect_nxt;
      select_r <= select_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;

  // crossbar enable and pin drivers
  assign crossbar_on = master_r[port_xbar_pkg::MASTER_XBAR_BIT];
  assign drv_en = crossbar_on ? drv_req : '0;

  // weak pullups, never on analog pins
  assign pullup_global_disable = master_r[port_xbar_pkg::MASTER_PUD_BIT];
  assign weak_pullup_en =
    pullup_global_disable ? '0 : ~pin_analog;

  // single peripheral routes, effective only with crossbar on
  always_comb begin
    route.timer1 = crossbar_on
      && route_r[port_xbar_pkg::ROUTE_T1_BIT];
    route.timer0 = crossbar_on
      && route_r[port_xbar_pkg::ROUTE_T0_BIT];
    route.pca_counter_input = crossbar_on
      && route_r[port_xbar_pkg::ROUTE_CNTIN_BIT];
    route.pca_module_pin = pca_pins;
    route.system_clock_out = crossbar_on
      && route_r[port_xbar_pkg::ROUTE_CLKOUT_BIT];
    route.lin = crossbar_on
      && master_r[port_xbar_pkg::MASTER_LIN_BIT];
  end

  // pca module pins, cumulative from module 0; reserved code routes none
  assign pca_cnt =
    route_r[port_xbar_pkg::ROUTE_PCA_MSB:port_xbar_pkg::ROUTE_PCA_LSB];

  for (genvar i = 0; i < port_xbar_pkg::PCA_MODULES; i++) begin : g_pca
    assign pca_pins[i] = crossbar_on
      && (pca_cnt != port_xbar_pkg::PCA_CNT_RESERVED)
      && (pca_cnt > 3'(i));
  end

  // two-flop pin synchroniser, ahead of any routing
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // per-port masked compare, recomputed every clock
  for (genvar p = 0; p < NP; p++) begin : g_match
    assign mismatch_nxt[p] = |((pin_sync_r[p*PW +: PW] ^ expect_r[p])
      & select_r[p]);
  end

  // mismatch level register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mismatch_r <= '0;
    end else begin
      mismatch_r <= mismatch_nxt;
    end
  end

  // event outputs toward interrupt and power logic
  assign port_mismatch = mismatch_r;
  assign mismatch_irq = |mismatch_r;
  assign mismatch_wake = |mismatch_r;

  // checks on routing, pullups and match logic
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // pca count field of the write data, for the count check
  assign wr_pca_cnt =
    sfr_wdata[port_xbar_pkg::ROUTE_PCA_MSB:port_xbar_pkg::ROUTE_PCA_LSB];

  chk_timer1_route_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE && crossbar_on
      && !(sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER))
    |=> route.timer1 == $past(sfr_wdata[port_xbar_pkg::ROUTE_T1_BIT]))
    else $error("timer1 route does not follow write");

  chk_timer0_route_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE && crossbar_on)
    |=> route.timer0 == $past(sfr_wdata[port_xbar_pkg::ROUTE_T0_BIT]))
    else $error("timer0 route does not follow write");

  chk_cntin_route_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE && crossbar_on)
    |=> route.pca_counter_input
      == $past(sfr_wdata[port_xbar_pkg::ROUTE_CNTIN_BIT]))
    else $error("pca counter input route does not follow write");

  chk_pca_module_count: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE && crossbar_on)
    |=> $countones(route.pca_module_pin)
      == (($past(wr_pca_cnt) == port_xbar_pkg::PCA_CNT_RESERVED) ? 0
        : int'($past(wr_pca_cnt)))
      && (route.pca_module_pin[0] || $countones(route.pca_module_pin) == 0))
    else $error("pca module pin count wrong");

  chk_clock_out_route: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_ROUTE && crossbar_on)
    |=> route.system_clock_out
      == $past(sfr_wdata[port_xbar_pkg::ROUTE_CLKOUT_BIT]))
    else $error("system clock route does not follow write");

  chk_pullup_disable_all: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER
      && sfr_wdata[port_xbar_pkg::MASTER_PUD_BIT])
    |=> weak_pullup_en == '0)
    else $error("weak pullup on while globally disabled");

  chk_crossbar_off_quiet: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER
      && !sfr_wdata[port_xbar_pkg::MASTER_XBAR_BIT])
    |=> !crossbar_on && drv_en == '0 && route == '0)
    else $error("pins driven or routed with crossbar off");

  chk_lin_route_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER)
    |=> route.lin == ($past(sfr_wdata[port_xbar_pkg::MASTER_LIN_BIT])
      && $past(sfr_wdata[port_xbar_pkg::MASTER_XBAR_BIT])))
    else $error("lin route does not follow write");

  chk_port0_compare_time: assert property (
    $past(arst_n, 3)
    |-> port_mismatch[0] == (|(($past(pin_in[7:0], 3)
      ^ $past(expect_r[0])) & $past(select_r[0]))))
    else $error("port0 mismatch wrong three cycles after pin");

  chk_port3_compare_time: assert property (
    $past(arst_n, 3)
    |-> port_mismatch[3] == (|(($past(pin_in[31:24], 3)
      ^ $past(expect_r[3])) & $past(select_r[3]))))
    else $error("port3 mismatch wrong three cycles after pin");

  chk_event_outputs: assert property (
    (mismatch_irq == (port_mismatch != '0)) && (mismatch_wake == mismatch_irq))
    else $error("mismatch event not on irq or wake");

  chk_select_zero_quiet: assert property (
    (select_r[1] == 8'h00) |=> !port_mismatch[1])
    else $error("excluded pins raised a mismatch");

  chk_expected_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_EXPECT[0])
    |=> expect_r[0] == $past(sfr_wdata))
    else $error("expected value not stored");

  chk_mismatch_held: assert property (
    (mismatch_nxt[2] && $stable(pin_sync_r[23:16]) && $stable(expect_r[2])
      && $stable(select_r[2])) [*2] |-> port_mismatch[2])
    else $error("mismatch dropped while values still differ");

  // bus, enable, pullup, pca routing and driver checks
  chk_crossbar_on_write: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER)
    |=> crossbar_on == $past(sfr_wdata[port_xbar_pkg::MASTER_XBAR_BIT]))
    else $error("crossbar enable does not follow write");

  chk_read_master: assert property (
    (sfr_rd && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER)
    |=> sfr_rdata == $past(master_r))
    else $error("master register read back wrong");

  chk_pullup_follow_analog: assert property (
    (sfr_wr && sfr_addr == port_xbar_pkg::ADDR_XBAR_MASTER
      && !sfr_wdata[port_xbar_pkg::MASTER_PUD_BIT])
    |=> weak_pullup_en == ~pin_analog)
    else $error("weak pullup wrong with pullups enabled");

  chk_pca_thermometer: assert property (
    ((route.pca_module_pin >> 1) & ~route.pca_module_pin) == '0)
    else $error("pca module pins not cumulative from module 0");

  chk_driver_pass: assert property (
    crossbar_on |-> drv_en == drv_req)
    else $error("driver request lost with crossbar on");

  // scenarios worth seeing
  cov_mismatch_rise: cover property ($rose(mismatch_irq));
  cov_crossbar_enable: cover property ($rose(crossbar_on));
  cov_all_pca_modules: cover property (route.pca_module_pin == 6'h3F);
  cov_mismatch_clear: cover property ($fell(port_mismatch[0]));
  cov_lin_route: cover property ($rose(route.lin));

endmodule : port_crossbar_and_match

/* File: src/port_xbar_pkg.sv */
package port_xbar_pkg;

  // port geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_W = 8;
  localparam int PIN_W = NUM_PORTS * PORT_W;

  // special function register addresses
  localparam logic [7:0] ADDR_XBAR_MASTER = 8'hC7;
  localparam logic [7:0] ADDR_XBAR_ROUTE = 8'hE2;
  localparam logic [7:0] ADDR_EXPECT [NUM_PORTS] = '{
    8'hF1, 8'hF3, 8'hB1, 8'hAE};
  localparam logic [7:0] ADDR_SELECT [NUM_PORTS] = '{
    8'hF2, 8'hF4, 8'hB2, 8'hAF};

  // reset values
  localparam logic [7:0] RST_XBAR_MASTER = 8'h00;
  localparam logic [7:0] RST_XBAR_ROUTE = 8'h00;
  localparam logic [7:0] RST_EXPECT = 8'hFF;
  localparam logic [7:0] RST_SELECT = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // routing register fields
  localparam int ROUTE_T1_BIT = 7;
  localparam int ROUTE_T0_BIT = 6;
  localparam int ROUTE_CNTIN_BIT = 5;
  localparam int ROUTE_PCA_MSB = 4;
  localparam int ROUTE_PCA_LSB = 2;
  localparam int ROUTE_CLKOUT_BIT = 1;

  // master register fields
  localparam int MASTER_PUD_BIT = 7;
  localparam int MASTER_XBAR_BIT = 6;
  localparam int MASTER_LIN_BIT = 0;

  // pca module routing
  localparam int PCA_MODULES = 6;
  localparam logic [2:0] PCA_CNT_RESERVED = 3'h7;

  // effective routing enables seen by the pin assigner
  typedef struct packed {
    logic timer1;
    logic timer0;
    logic pca_counter_input;
    logic [PCA_MODULES-1:0] pca_module_pin;
    logic system_clock_out;
    logic lin;
  } route_s;

endpackage : port_xbar_pkg

/* File: tb/port_crossbar_and_match_test.sv */
module port_crossbar_and_match_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = port_xbar_pkg::PIN_W;
  localparam logic [7:0] EXP_RST = port_xbar_pkg::RST_EXPECT;
  localparam logic [7:0] SEL_RST = port_xbar_pkg::RST_SELECT;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [W-1:0] pin_in = 32'hFFFFFFFF;
  logic [W-1:0] pin_analog = 32'h0000000F;
  logic [W-1:0] drv_req = 32'hFFFFFFFF;
  logic [7:0] sfr_rdata;
  logic [W-1:0] drv_en;
  logic [W-1:0] weak_pullup_en;
  port_xbar_pkg::route_s route;
  logic crossbar_on;
  logic [3:0] port_mismatch;
  logic mismatch_irq;
  logic mismatch_wake;
  int err_count = 0;
  int compares = 0;

  // free-running system clock
  always #50 clock = ~clock;

  port_crossbar_and_match u_port_crossbar_and_match (
    .clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .pin_in(pin_in), .pin_analog(pin_analog), .drv_req(drv_req),
    .drv_en(drv_en), .weak_pullup_en(weak_pullup_en), .route(route),
    .crossbar_on(crossbar_on), .port_mismatch(port_mismatch),
    .mismatch_irq(mismatch_irq), .mismatch_wake(mismatch_wake)
  );

  // expected routing outputs from register contents
  function automatic port_xbar_pkg::route_s route_exp(
    input logic [7:0] m,
    input logic [7:0] r
  );
    port_xbar_pkg::route_s e;
    logic [2:0] n;
    n = r[4:2];
    e.timer1 = r[7];
    e.timer0 = r[6];
    e.pca_counter_input = r[5];
    e.pca_module_pin = (n == 3'h7) ? 6'h00
      : 6'((7'h01 << n) - 7'h01);
    e.system_clock_out = r[1];
    e.lin = m[0];
    if (!m[6]) e = '0;
    return e;
  endfunction : route_exp

  // expected per-port mismatch flags
  function automatic logic [3:0] mism_exp(
    input logic [31:0] p,
    input logic [31:0] e,
    input logic [31:0] s
  );
    logic [31:0] d;
    logic [3:0] v;
    d = (p ^ e) & s;
    for (int i = 0; i < 4; i++) v[i] = |d[i*8 +: 8];
    return v;
  endfunction : mism_exp

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    @(posedge clock);
    #1 chk("sfr_rdata", 32'(exp), 32'(sfr_rdata));
  endtask : rd

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung run
  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    logic [7:0] m;
    logic [7:0] r;
    logic [31:0] ex;
    logic [31:0] sl;
    logic [31:0] p;
    logic [31:0] pu;
    logic [3:0] mx;
    port_xbar_pkg::route_s re;
    void'($urandom(6304));
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    #1 chk("crossbar_on", 32'h0, 32'(crossbar_on));
    chk("drv_en", 32'h0, drv_en);
    chk("route", 32'h0, 32'(route));
    chk("weak_pullup_en", ~pin_analog, weak_pullup_en);
    chk("port_mismatch", 32'h0, 32'(port_mismatch));
    for (int i = 0; i < 4; i++) begin
      rd(port_xbar_pkg::ADDR_EXPECT[i], EXP_RST);
      rd(port_xbar_pkg::ADDR_SELECT[i], SEL_RST);
    end
    rd(8'hC7, port_xbar_pkg::RST_XBAR_MASTER);
    rd(8'hE2, port_xbar_pkg::RST_XBAR_ROUTE);
    rd(8'h00, port_xbar_pkg::RDATA_UNMAPPED);
    // routing enables over every pca count, crossbar on and off
    for (int k = 0; k < 16; k++) begin
      m = 8'($urandom) & 8'hC1;
      m[6] = k[3];
      r = 8'($urandom) & 8'hFE;
      r[4:2] = k[2:0];
      @(posedge clock);
      drv_req <= $urandom;
      pin_analog <= $urandom;
      wr(8'hE2, r);
      wr(8'hC7, m);
      rd(8'hE2, r);
      rd(8'hC7, m);
      re = route_exp(m, r);
      pu = m[7] ? 32'h0 : ~pin_analog;
      chk("route", 32'(re), 32'(route));
      chk("crossbar_on", 32'(m[6]), 32'(crossbar_on));
      chk("drv_en", drv_req & {W{m[6]}}, drv_en);
      chk("weak_pullup_en", pu, weak_pullup_en);
    end
    // port match with random crossbar state, corners first
    for (int k = 0; k < 24; k++) begin
      ex = $urandom;
      sl = (k == 0) ? 32'h0 : ((k == 1) ? 32'hFFFFFFFF : $urandom);
      p = (k < 2) ? ex : (k[0] ? ex ^ (32'h1 << ($urandom % 32)) : $urandom);
      wr(8'hC7, 8'($urandom) & 8'hC1);
      for (int i = 0; i < 4; i++) begin
        wr(port_xbar_pkg::ADDR_EXPECT[i], ex[i*8 +: 8]);
        wr(port_xbar_pkg::ADDR_SELECT[i], sl[i*8 +: 8]);
      end
      @(posedge clock);
      pin_in <= (k == 0) ? ~ex : p;
      repeat (5) @(posedge clock);
      #1 mx = mism_exp(pin_in, ex, sl);
      chk("port_mismatch", 32'(mx), 32'(port_mismatch));
      chk("mismatch_irq", 32'(|mx), 32'(mismatch_irq));
      chk("mismatch_wake", 32'(|mx), 32'(mismatch_wake));
      repeat (3) @(posedge clock);
      #1 chk("port_mismatch", 32'(mx), 32'(port_mismatch));
    end
    tally_and_finish();
  end
endmodule : port_crossbar_and_match_test
